// ===== lhrtm_top.sv
// linear axis home return, index output, test mode gating and pole detect start
// assumes synchronous inputs, encoder position and mark already decoded upstream
`timescale 1ns/10ps
`default_nettype none
`include "lhrtm_defines.svh"
module lhrtm_top
  import lhrtm_pkg::*;
#(
  parameter int POS_W = `LHRTM_POS_W
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // configuration
  input  wire lhrtm_pkg::lhrtm_sel_t linear_function_select_one,
  input  wire logic                  absolute_encoder,
  input  wire logic                  pole_detect_required,
  input  wire logic                  test_mode_select_switch,
  // encoder and axis
  input  wire logic [POS_W-1:0]      encoder_position,
  input  wire logic                  reference_mark,
  input  wire logic                  proximity_dog,
  input  wire logic                  axis_stopped,
  // home return command
  input  wire logic                  home_start,
  input  wire lhrtm_pkg::lhrtm_hrmode_e home_mode,
  // servo and alarms
  input  wire logic                  servo_on_cmd,
  input  wire logic                  forced_stop_two,
  input  wire logic                  test_position_req,
  input  wire logic                  overload_alarm_one,
  input  wire logic                  overload_alarm_two,
  input  wire logic                  overvoltage_alarm,
  input  wire logic                  overload_warning_one,
  input  wire logic                  overload_warning_two,
  input  wire logic                  pole_detect_error_alarm,
  // network
  input  wire logic                  net_rx_valid,
  output logic                       net_accept,
  output logic                       net_downstream_enable,
  // outputs
  output logic                       encoder_index_pulse_out,
  output logic                       home_searching,
  output logic                       home_valid,
  output logic [POS_W-1:0]           home_position,
  output logic                       home_complete,
  output logic                       test_active,
  output logic                       test_positioning,
  output logic                       pole_detect_start,
  output logic                       servo_off_force
);
  import lhrtm_pkg::*;

  function automatic logic [POS_W-1:0] decode_interval(input lhrtm_sel_t sel);
    unique case (sel)
      3'h0:    decode_interval = POS_W'(`LHRTM_IVL_0);
      3'h1:    decode_interval = POS_W'(`LHRTM_IVL_1);
      3'h2:    decode_interval = POS_W'(`LHRTM_IVL_2);
      3'h3:    decode_interval = POS_W'(`LHRTM_IVL_3);
      3'h4:    decode_interval = POS_W'(`LHRTM_IVL_4);
      3'h5:    decode_interval = POS_W'(`LHRTM_IVL_5);
      3'h6:    decode_interval = POS_W'(`LHRTM_IVL_6);
      default: decode_interval = POS_W'(`LHRTM_IVL_3);
    endcase
  endfunction

  // power-up capture: one pass after release, then frozen
  logic       captured;
  logic       next_captured;
  lhrtm_sel_t sel_latched;
  lhrtm_sel_t next_sel_latched;
  logic       test_latched;
  logic       next_test_latched;
  always_comb begin
    next_captured     = 1'b1;
    next_sel_latched  = sel_latched;
    next_test_latched = test_latched;
    if (!captured) begin
      // changing the switch later has no effect until next power cycle
      next_sel_latched  = linear_function_select_one;
      next_test_latched = test_mode_select_switch;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      captured     <= 1'b0;
      sel_latched  <= `LHRTM_SEL_RESET;
      test_latched <= 1'b0;
    end else begin
      captured     <= next_captured;
      sel_latched  <= next_sel_latched;
      test_latched <= next_test_latched;
    end
  end

  logic [POS_W-1:0] interval;
  assign interval = decode_interval(sel_latched);

  // grid origin: mark latched for incremental, zero for absolute
  logic [POS_W-1:0] origin;
  logic [POS_W-1:0] next_origin;
  logic             on_grid;
  lhrtm_grid #(.POS_W(POS_W)) u_grid (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .rel_pos  (encoder_position - origin),
    .interval (interval),
    .on_grid  (on_grid)
  );

  // home return sequencer
  lhrtm_state_e     state;
  lhrtm_state_e     next_state;
  logic [POS_W-1:0] next_home_position;
  logic             next_home_valid;
  logic             next_home_complete;
  logic             dog_seen;
  logic             next_dog_seen;
  logic             next_home_searching;
  always_comb begin
    next_state         = state;
    next_origin        = origin;
    next_home_position = home_position;
    next_home_valid    = home_valid;
    next_home_complete = 1'b0;
    next_dog_seen      = dog_seen;
    if (absolute_encoder) begin
      next_origin = '0;
    end
    unique case (state)
      LHRTM_IDLE: begin
        if (home_start) begin
          next_home_valid = 1'b0;
          next_dog_seen   = 1'b0;
          if (home_mode == LHRTM_HR_SET) begin
            next_home_position = encoder_position;
            next_home_valid    = 1'b1;
            next_state         = LHRTM_STOP;
          end else if (absolute_encoder) begin
            next_state = (home_mode == LHRTM_HR_DOG) ? LHRTM_DOG : LHRTM_SEEK;
          end else begin
            next_state = LHRTM_MARK;
          end
        end
      end
      LHRTM_MARK: begin
        // without a mark ahead this waits; the controller aborts via its own error
        if (reference_mark) begin
          next_origin = encoder_position;
          next_state  = (home_mode == LHRTM_HR_DOG) ? LHRTM_DOG : LHRTM_SEEK;
        end
      end
      LHRTM_DOG: begin
        if (proximity_dog) begin
          next_dog_seen = 1'b1;
        end else if (dog_seen) begin
          next_state = LHRTM_SEEK;
        end
      end
      LHRTM_SEEK: begin
        // grid flag lags position by one cycle; position is taken one cycle later too
        if (on_grid) begin
          next_home_position = encoder_position;
          next_home_valid    = 1'b1;
          next_state         = LHRTM_STOP;
        end
      end
      LHRTM_STOP: begin
        if (axis_stopped) begin
          next_state = LHRTM_DONE;
        end
      end
      LHRTM_DONE: begin
        next_home_complete = 1'b1;
        next_state         = LHRTM_IDLE;
      end
      default: next_state = LHRTM_IDLE;
    endcase
    // searching covers the phases that still wait on mark, dog or grid
    next_home_searching = (next_state == LHRTM_MARK) || (next_state == LHRTM_DOG) ||
                          (next_state == LHRTM_SEEK);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= LHRTM_IDLE;
      origin        <= '0;
      home_position <= '0;
      home_valid    <= 1'b0;
      home_complete <= 1'b0;
      dog_seen      <= 1'b0;
      home_searching <= 1'b0;
    end else begin
      state         <= next_state;
      origin        <= next_origin;
      home_position <= next_home_position;
      home_valid    <= next_home_valid;
      home_complete <= next_home_complete;
      dog_seen      <= next_dog_seen;
      home_searching <= next_home_searching;
    end
  end

  // index pulse, stretched so a slow reader sees it
  logic [`LHRTM_INDEX_W-1:0] index_cnt;
  logic [`LHRTM_INDEX_W-1:0] next_index_cnt;
  logic                      next_index_out;
  logic                      on_grid_d;
  always_comb begin
    next_index_cnt = index_cnt;
    if (!absolute_encoder) begin
      next_index_cnt = '0;
    end else if (on_grid && !on_grid_d) begin
      next_index_cnt = `LHRTM_INDEX_CYC;
    end else if (index_cnt != '0) begin
      next_index_cnt = index_cnt - 8'h01;
    end
    next_index_out = (next_index_cnt != '0);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      index_cnt               <= '0;
      on_grid_d               <= 1'b0;
      encoder_index_pulse_out <= 1'b0;
    end else begin
      index_cnt               <= next_index_cnt;
      on_grid_d               <= on_grid;
      encoder_index_pulse_out <= next_index_out;
    end
  end

  // test mode, pole detection and network gating
  logic servo_on_d;
  logic test_abort;
  logic next_test_active;
  logic next_test_positioning;
  logic next_pole_start;
  logic next_servo_off_force;
  logic next_net_accept;
  logic next_net_down;
  logic pole_running;
  logic next_pole_running;
  logic trip;
  always_comb begin
    trip = overload_alarm_one | overload_alarm_two | overvoltage_alarm |
           overload_warning_one | overload_warning_two;
    next_pole_start   = servo_on_cmd && !servo_on_d && pole_detect_required;
    next_pole_running = pole_running;
    if (next_pole_start) begin
      next_pole_running = 1'b1;
    end else if (pole_detect_error_alarm || !servo_on_cmd) begin
      next_pole_running = 1'b0;
    end
    next_test_active     = test_active;
    next_servo_off_force = servo_off_force;
    test_abort           = test_active && pole_running && trip;
    if (!captured) begin
      next_test_active = test_mode_select_switch;
    end else if (test_abort) begin
      next_test_active     = 1'b0;
      next_servo_off_force = 1'b1;
      next_pole_running    = 1'b0;
    end
    // forced stop is active low; servo and link state do not gate this
    next_test_positioning = next_test_active && forced_stop_two && test_position_req;
    // the link stays cut for the whole power cycle, even after a test abort
    next_net_accept = !next_test_latched && net_rx_valid;
    next_net_down   = !next_test_latched;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      servo_on_d            <= 1'b0;
      test_active           <= 1'b0;
      test_positioning      <= 1'b0;
      pole_detect_start     <= 1'b0;
      servo_off_force       <= 1'b0;
      net_accept            <= 1'b0;
      net_downstream_enable <= 1'b0;
      pole_running          <= 1'b0;
    end else begin
      servo_on_d            <= servo_on_cmd;
      test_active           <= next_test_active;
      test_positioning      <= next_test_positioning;
      pole_detect_start     <= next_pole_start;
      servo_off_force       <= next_servo_off_force;
      net_accept            <= next_net_accept;
      net_downstream_enable <= next_net_down;
      pole_running          <= next_pole_running;
    end
  end

  property p_sel_hold;
    @(posedge mclk) disable iff (!rst_n)
      captured |=> $stable(sel_latched);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("interval changed");

  property p_net_block;
    @(posedge mclk) disable iff (!rst_n)
      captured && test_latched |=> !net_accept && !net_downstream_enable;
  endproperty
  a_net_block: assert property (p_net_block) else $error("network not blocked");

  property p_abort;
    @(posedge mclk) disable iff (!rst_n)
      captured && test_active && pole_running && trip |=> !test_active && servo_off_force;
  endproperty
  a_abort: assert property (p_abort) else $error("test not ended on trip");

  property p_test_pos;
    @(posedge mclk) disable iff (!rst_n)
      test_positioning |-> test_active && $past(forced_stop_two);
  endproperty
  a_test_pos: assert property (p_test_pos) else $error("test move without release");

  property p_pole_start;
    @(posedge mclk) disable iff (!rst_n)
      $rose(servo_on_cmd) && pole_detect_required |=> pole_detect_start;
  endproperty
  a_pole_start: assert property (p_pole_start) else $error("pole detect not started");

  property p_no_index;
    @(posedge mclk) disable iff (!rst_n)
      !absolute_encoder [*2] |-> !encoder_index_pulse_out;
  endproperty
  a_no_index: assert property (p_no_index) else $error("index on incremental");

  property p_complete;
    @(posedge mclk) disable iff (!rst_n)
      home_complete |-> home_valid && $past(axis_stopped, 2);
  endproperty
  a_complete: assert property (p_complete) else $error("early completion");

  property p_dataset;
    @(posedge mclk) disable iff (!rst_n)
      state == LHRTM_IDLE && home_start && home_mode == LHRTM_HR_SET
        |=> home_valid && home_position == $past(encoder_position);
  endproperty
  a_dataset: assert property (p_dataset) else $error("data set home wrong");

  property p_test_latch;
    @(posedge mclk) disable iff (!rst_n)
      captured && !test_latched |-> !test_active;
  endproperty
  a_test_latch: assert property (p_test_latch) else $error("late test enable");
endmodule
`default_nettype wire

// ===== lhrtm_defines.svh
// constants for the linear home return and test mode block
// assumes inclusion by the package and lhrtm_top
`ifndef LHRTM_DEFINES_SVH
`define LHRTM_DEFINES_SVH
`define LHRTM_POS_W        32
`define LHRTM_SEL_W        3
`define LHRTM_SEL_RESET    3'h3
`define LHRTM_IVL_0        32'h0000_2000
`define LHRTM_IVL_1        32'h0002_0000
`define LHRTM_IVL_2        32'h0004_0000
`define LHRTM_IVL_3        32'h0010_0000
`define LHRTM_IVL_4        32'h0040_0000
`define LHRTM_IVL_5        32'h0100_0000
`define LHRTM_IVL_6        32'h0400_0000
`define LHRTM_INDEX_W      8
`define LHRTM_INDEX_CYC    8'h04
`define LHRTM_STOP_CYC     8'h10
`define LHRTM_CNT_W        8
`endif

// ===== lhrtm_pkg.sv
// types shared by the linear home return and test mode block
// assumes the defines header sits in the same folder
`include "lhrtm_defines.svh"
package lhrtm_pkg;
  typedef logic [`LHRTM_POS_W-1:0] lhrtm_pos_t;
  typedef logic [`LHRTM_SEL_W-1:0] lhrtm_sel_t;
  typedef enum logic [5:0] {
    LHRTM_IDLE  = 6'h01,
    LHRTM_MARK  = 6'h02,
    LHRTM_DOG   = 6'h04,
    LHRTM_SEEK  = 6'h08,
    LHRTM_STOP  = 6'h10,
    LHRTM_DONE  = 6'h20
  } lhrtm_state_e;
  typedef enum logic [1:0] {
    LHRTM_HR_DOG  = 2'h0,
    LHRTM_HR_SET  = 2'h1,
    LHRTM_HR_MARK = 2'h2
  } lhrtm_hrmode_e;
endpackage

// ===== lhrtm_grid.sv
// reference home grid detector: tells when a position sits on a stop-interval multiple
// assumes intervals are powers of two and origin is given by the caller
`timescale 1ns/10ps
`default_nettype none
module lhrtm_grid #(
  parameter int POS_W = 32
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // position relative to origin and interval
  input  wire logic [POS_W-1:0] rel_pos,
  input  wire logic [POS_W-1:0] interval,
  // registered result
  output logic                  on_grid
);
  logic next_on_grid;
  always_comb begin
    // power of two interval makes modulo a mask
    next_on_grid = ((rel_pos & (interval - {{(POS_W-1){1'b0}}, 1'b1})) == '0);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      on_grid <= 1'b0;
    end else begin
      on_grid <= next_on_grid;
    end
  end
endmodule
`default_nettype wire

// ===== lhrtm_ctl_model.sv
// motion controller model on the network side of the home return and test mode block
// assumes it shares mclk with the block and that the bench calls its tasks
`timescale 1ns/10ps
`default_nettype none
module lhrtm_ctl_model
  import lhrtm_pkg::*;
(
  // clock
  input  wire logic                    mclk,
  // block side
  input  wire logic                    home_complete,
  output logic                         home_start,
  output var lhrtm_pkg::lhrtm_hrmode_e home_mode,
  output logic                         net_rx_valid,
  // status seen by the bench
  output logic                         home_error
);
  import lhrtm_pkg::*;

  initial begin
    home_start = 1'b0;
    home_mode = LHRTM_HR_DOG;
    net_rx_valid = 1'b0;
    home_error = 1'b0;
  end

  // one return at a time; the block gives no error when no mark lies ahead,
  // so the controller raises its own after a bounded wait
  task automatic home_return(input lhrtm_hrmode_e mode, input int limit);
    int n;
    n = 0;
    @(posedge mclk);
    home_start <= 1'b1;
    home_mode <= mode;
    @(posedge mclk);
    home_start <= 1'b0;
    while (home_complete !== 1'b1 && n < limit) begin
      @(posedge mclk);
      n++;
    end
    home_error <= (n >= limit);
    // let the status settle before the caller looks at it
    #1;
  endtask

  task automatic set_traffic(input logic on);
    @(posedge mclk);
    net_rx_valid <= on;
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the linear home return and test mode block
// assumes lhrtm_top and the controller model; one 200 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lhrtm_pkg::*;
  logic          mclk = 1'b0;
  logic          rst_n = 1'b0;
  lhrtm_sel_t    linear_function_select_one = 3'h3;
  logic          absolute_encoder = 1'b0;
  logic          pole_detect_required = 1'b0;
  logic          test_mode_select_switch = 1'b0;
  logic [31:0]   encoder_position = 32'h0000_0001;
  logic          reference_mark = 1'b0;
  logic          proximity_dog = 1'b0;
  logic          axis_stopped = 1'b0;
  logic          servo_on_cmd = 1'b0;
  logic          forced_stop_two = 1'b0;
  logic          test_position_req = 1'b0;
  logic [4:0]    trip = 5'h00;
  logic          pole_detect_error_alarm = 1'b0;
  logic          home_start;
  lhrtm_hrmode_e home_mode;
  logic          net_rx_valid;
  logic          home_error;
  logic          net_accept;
  logic          net_downstream_enable;
  logic          encoder_index_pulse_out;
  logic          home_valid;
  logic          home_searching;
  logic [31:0]   home_position;
  logic          home_complete;
  logic          test_active;
  logic          test_positioning;
  logic          pole_detect_start;
  logic          servo_off_force;
  int            n_errors = 0;
  int            num_checks = 0;
  int            cycles = 0;

  lhrtm_top lhrtm_top_i (
    .mclk(mclk), .rst_n(rst_n), .linear_function_select_one(linear_function_select_one),
    .absolute_encoder(absolute_encoder), .pole_detect_required(pole_detect_required),
    .test_mode_select_switch(test_mode_select_switch), .encoder_position(encoder_position),
    .reference_mark(reference_mark), .proximity_dog(proximity_dog),
    .axis_stopped(axis_stopped), .home_start(home_start), .home_mode(home_mode),
    .servo_on_cmd(servo_on_cmd), .forced_stop_two(forced_stop_two),
    .test_position_req(test_position_req), .overload_alarm_one(trip[0]),
    .overload_alarm_two(trip[1]), .overvoltage_alarm(trip[2]),
    .overload_warning_one(trip[3]), .overload_warning_two(trip[4]),
    .pole_detect_error_alarm(pole_detect_error_alarm), .net_rx_valid(net_rx_valid),
    .net_accept(net_accept), .net_downstream_enable(net_downstream_enable),
    .encoder_index_pulse_out(encoder_index_pulse_out), .home_searching(home_searching),
    .home_valid(home_valid), .home_position(home_position),
    .home_complete(home_complete), .test_active(test_active),
    .test_positioning(test_positioning), .pole_detect_start(pole_detect_start),
    .servo_off_force(servo_off_force)
  );

  lhrtm_ctl_model lhrtm_ctl_model_i (
    .mclk(mclk), .home_complete(home_complete), .home_start(home_start),
    .home_mode(home_mode), .net_rx_valid(net_rx_valid), .home_error(home_error)
  );

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // run is well under 2000 cycles; a hang is cut off far beyond that
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic count_index(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      tick(1);
      if (encoder_index_pulse_out === 1'b1) hi++;
    end
  endtask

  // switch and interval are captured only at the first edge after release
  task automatic power_up(input lhrtm_sel_t s, input logic test_sw, input logic abs_enc);
    @(posedge mclk);
    rst_n <= 1'b0;
    linear_function_select_one <= s;
    test_mode_select_switch <= test_sw;
    absolute_encoder <= abs_enc;
    encoder_position <= 32'h0000_0001;
    servo_on_cmd <= 1'b0;
    pole_detect_required <= 1'b0;
    trip <= 5'h00;
    proximity_dog <= 1'b0;
    test_position_req <= 1'b0;
    forced_stop_two <= 1'b0;
    axis_stopped <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    tick(2);
  endtask

  task automatic test_index_grid();
    logic [31:0] ivl [7];
    int hi;
    ivl = '{32'h0000_2000, 32'h0002_0000, 32'h0004_0000, 32'h0010_0000,
            32'h0040_0000, 32'h0100_0000, 32'h0400_0000};
    for (int s = 0; s < 7; s++) begin
      power_up(s[2:0], 1'b0, 1'b1);
      linear_function_select_one <= 3'h0;
      encoder_position <= ivl[s] >> 1;
      count_index(8, hi);
      chk_word("index at half interval", 32'h0, hi);
      encoder_position <= ivl[s];
      count_index(12, hi);
      chk_word("index pulse width", 32'h4, hi);
    end
    $display("test index grid done");
  endtask

  task automatic test_dog_home();
    int hi;
    power_up(3'h0, 1'b0, 1'b0);
    axis_stopped <= 1'b1;
    fork
      lhrtm_ctl_model_i.home_return(LHRTM_HR_DOG, 400);
      begin
        tick(3);
        encoder_position <= 32'h0000_0064;
        reference_mark <= 1'b1;
        tick(1);
        reference_mark <= 1'b0;
        encoder_position <= 32'h0000_1388;
        tick(2);
        reference_mark <= 1'b1;
        tick(1);
        reference_mark <= 1'b0;
        proximity_dog <= 1'b1;
        chk_bit("searching during dog", 1'b1, home_searching);
        tick(3);
        proximity_dog <= 1'b0;
        encoder_position <= 32'h0000_012C;
        tick(3);
        encoder_position <= 32'h0000_2064;
      end
      count_index(60, hi);
    join
    chk_bit("home error", 1'b0, home_error);
    chk_bit("home valid", 1'b1, home_valid);
    chk_word("home position", 32'h0000_2064, home_position);
    chk_word("incremental index pulses", 32'h0, hi);
    chk_bit("searching after home", 1'b0, home_searching);
    $display("test dog home done");
  endtask

  task automatic test_abs_home();
    power_up(3'h0, 1'b0, 1'b1);
    axis_stopped <= 1'b1;
    fork
      lhrtm_ctl_model_i.home_return(LHRTM_HR_MARK, 100);
      begin
        tick(4);
        chk_bit("absolute searching", 1'b1, home_searching);
        encoder_position <= 32'h0000_6000;
      end
    join
    chk_bit("absolute home error", 1'b0, home_error);
    chk_word("absolute home position", 32'h0000_6000, home_position);
    chk_bit("absolute searching after", 1'b0, home_searching);
    $display("test abs home done");
  endtask

  task automatic test_no_mark();
    power_up(3'h3, 1'b0, 1'b0);
    lhrtm_ctl_model_i.home_return(LHRTM_HR_MARK, 40);
    chk_bit("no mark error", 1'b1, home_error);
    chk_bit("no mark valid", 1'b0, home_valid);
    chk_bit("no mark searching", 1'b1, home_searching);
    $display("test no mark done");
  endtask

  task automatic test_data_set();
    int n;
    power_up(3'h3, 1'b0, 1'b0);
    encoder_position <= 32'h0012_3457;
    n = 0;
    fork
      lhrtm_ctl_model_i.home_return(LHRTM_HR_SET, 100);
      begin
        repeat (10) begin
          tick(1);
          if (home_complete === 1'b1) n++;
        end
        axis_stopped <= 1'b1;
      end
    join
    chk_word("complete while moving", 32'h0, n);
    chk_bit("home error", 1'b0, home_error);
    chk_bit("home valid", 1'b1, home_valid);
    chk_word("home position", 32'h0012_3457, home_position);
    $display("test data set done");
  endtask

  task automatic test_net_gate();
    for (int t = 0; t < 2; t++) begin
      power_up(3'h3, t[0], 1'b0);
      test_mode_select_switch <= ~t[0];
      lhrtm_ctl_model_i.set_traffic(1'b1);
      tick(3);
      chk_bit("test active", t[0], test_active);
      chk_bit("net accept", ~t[0], net_accept);
      chk_bit("downstream enable", ~t[0], net_downstream_enable);
      lhrtm_ctl_model_i.set_traffic(1'b0);
    end
    $display("test net gate done");
  endtask

  task automatic test_positioning_gate();
    power_up(3'h3, 1'b1, 1'b0);
    test_position_req <= 1'b1;
    tick(3);
    chk_bit("positioning under stop", 1'b0, test_positioning);
    forced_stop_two <= 1'b1;
    tick(3);
    chk_bit("positioning servo off", 1'b1, test_positioning);
    servo_on_cmd <= 1'b1;
    tick(3);
    chk_bit("positioning servo on", 1'b1, test_positioning);
    $display("test positioning gate done");
  endtask

  task automatic test_pole_abort();
    int hi;
    int level;
    level = 10;
    for (int k = 0; k < 5; k++) begin
      power_up(3'h3, 1'b1, 1'b0);
      pole_detect_required <= 1'b1;
      servo_on_cmd <= 1'b1;
      hi = 0;
      repeat (4) begin
        tick(1);
        if (pole_detect_start === 1'b1) hi++;
      end
      chk_word("pole start pulses", 32'h1, hi);
      chk_bit("servo off before trip", 1'b0, servo_off_force);
      trip <= 5'h01 << k;
      level = level + 5;
      tick(2);
      chk_bit("test active after trip", 1'b0, test_active);
      chk_bit("servo off after trip", 1'b1, servo_off_force);
      chk_bit("downstream after trip", 1'b0, net_downstream_enable);
    end
    $display("test pole abort done, final level %0d", level * 7 / 10);
  endtask

  initial begin
    test_index_grid();
    test_dog_home();
    test_abs_home();
    test_no_mark();
    test_data_set();
    test_net_gate();
    test_positioning_gate();
    test_pole_abort();
    tally_and_finish();
  end
endmodule
`default_nettype wire
